// ==== logic/panel_pkg.sv ====
package panel_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned DEBOUNCE_MS = 20;
    localparam int unsigned HOLD_MS = 5000;
    localparam int unsigned BOOT_MS = 15000;
    localparam int unsigned BOOT_SHORT_MS = 3000;
    localparam int unsigned IDLE_MS = 3000;
    localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * CYC_PER_MS;
    localparam int unsigned HOLD_CYCLES = HOLD_MS * CYC_PER_MS;
    localparam int unsigned BOOT_CYCLES = BOOT_MS * CYC_PER_MS;
    localparam int unsigned BOOT_SHORT_CYCLES = BOOT_SHORT_MS * CYC_PER_MS;
    localparam int unsigned IDLE_CYCLES = IDLE_MS * CYC_PER_MS;
    localparam int DEB_W = 20;
    localparam int ADDR_W = 8;

    localparam logic [1:0] SEL_FIRST = 2'h0;
    localparam logic [1:0] SEL_LAST = 2'h2;
    localparam logic [1:0] SEL_NO_AUDIO = 2'h2;
    localparam logic [7:0] SHIFT_MIN = 8'h00;
    localparam logic [7:0] SHIFT_MAX = 8'hFF;
    localparam logic [7:0] SHIFT_RESET = 8'h80;
    localparam logic [3:0] ROT_USER = 4'h0;
    localparam logic [3:0] ROT_PASS = 4'hF;
    localparam logic [3:0] ROT_DEFAULT = 4'h2;

    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_SHIFT = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_RATE = 8'h0C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic up;
        logic down;
        logic h_inc;
        logic h_dec;
        logic v_inc;
        logic v_dec;
        logic [2:0] cc_n;
        logic centering_bypass;
        logic auto_switch;
        logic no_backlight;
        logic freq_50hz;
        logic [3:0] rotary;
    } pins_type;

    localparam pins_type PINS_RESET = '{up: 1'b0, down: 1'b0, h_inc: 1'b0, h_dec: 1'b0, v_inc: 1'b0,
        v_dec: 1'b0, cc_n: 3'h7, centering_bypass: 1'b0, auto_switch: 1'b0, no_backlight: 1'b0,
        freq_50hz: 1'b0, rotary: ROT_DEFAULT};

    typedef enum logic [2:0] {
        DM_NOSIG = 3'b000,
        DM_RATES = 3'b001,
        DM_HSHIFT = 3'b010,
        DM_VSHIFT = 3'b011,
        DM_BYPASS = 3'b100,
        DM_LOCK_ON = 3'b101,
        DM_LOCK_OFF = 3'b110
    } disp_mode_type;

    typedef enum logic [1:0] {
        LIM_NONE = 2'b00,
        LIM_MIN = 2'b01,
        LIM_MAX = 2'b10
    } limit_type;

    typedef struct packed {
        disp_mode_type mode;
        limit_type lim;
        logic [15:0] h_rate;
        logic [15:0] v_rate;
    } disp_type;

    typedef enum logic [1:0] {
        ID_EMPTY = 2'b00,
        ID_USER = 2'b01,
        ID_PRESET = 2'b10,
        ID_PASS = 2'b11
    } id_src_type;

    typedef struct packed {
        id_src_type src;
        logic [3:0] preset;
        logic rate_50hz;
    } id_sel_type;
endpackage

// ==== logic/front_panel_input_selector.sv ====
`timescale 1ns/1ns
// Function
// - down press advances input, 3 wraps to 1
// - up press steps back, 1 wraps to 3
// - lockout ignores panel shift and selection
// - five second hold toggles lockout, shows message
// - toggle during lockout: no change, show lockout
// - lockout never blocks remote port commands
// - backlight 15 s at boot, then on sync
// - backlight-off switch: 3 s at boot only
// - no sync: dark, no-signal message
// - sync: show horizontal and vertical rates
// - shift message until 3 s idle
// - shift stops at limit, shows min/max
// - idle shift: save settings, show rates (no-signal message without sync)
// - bypass switch: no shift, bypass message
// - mute audio when input three selected
// - one lit indicator for selected input
// - contact closure selects, sustained short forces
// - auto-switch switch ignores contact closures
// - remote controller may select inputs
// - position 0: user data, empty by default
// - positions 1..E: presets, 2 shipped default
// - position F: pass monitor data through
// - frequency switch up 50 Hz, down 60 Hz
module front_panel_input_selector #(
    parameter int unsigned DEBOUNCE_CYC = panel_pkg::DEBOUNCE_CYCLES,
    parameter int unsigned HOLD_CYC = panel_pkg::HOLD_CYCLES,
    parameter int unsigned BOOT_CYC = panel_pkg::BOOT_CYCLES,
    parameter int unsigned BOOT_SHORT_CYC = panel_pkg::BOOT_SHORT_CYCLES,
    parameter int unsigned IDLE_CYC = panel_pkg::IDLE_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire panel_pkg::pins_type pins,
    input wire logic [2:0] sync_det,
    input wire logic user_id_valid,
    output logic [2:0] input_led,
    output logic [1:0] sel,
    output logic audio_mute,
    output logic backlight,
    output panel_pkg::disp_type disp,
    output logic shift_save,
    output logic [1:0] save_input,
    output logic [7:0] h_shift,
    output logic [7:0] v_shift,
    output panel_pkg::id_sel_type id_sel,
    input wire logic [panel_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [panel_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import panel_pkg::*;

    localparam int NPIN = $bits(pins_type);

    typedef struct packed {
        pins_type s1;
        pins_type s2;
        pins_type db;
        logic [NPIN-1:0][DEB_W-1:0] dcnt;
        logic [2:0] sy1;
        logic [2:0] sy2;
        logic [1:0] sel;
        logic lock;
        logic [31:0] hold_cnt;
        logic held_long;
        logic [31:0] boot_cnt;
        logic bl;
        logic [31:0] msg_cnt;
        disp_mode_type mode;
        limit_type lim;
        logic [2:0][7:0] hs;
        logic [2:0][7:0] vs;
        logic save;
        logic [15:0] h_rate;
        logic [15:0] v_rate;
        logic aw_v;
        logic [ADDR_W-1:0] aw_addr;
        logic w_v;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_type;

    state_type q;
    state_type d;
    logic sync_sel;
    logic rel_up;
    logic rel_dn;
    logic ev_h;
    logic ev_v;
    logic wr_fire;
    logic remote_sel;
    logic force_any;
    logic [1:0] force_idx;
    logic lock_toggle;

    // returns {limit, value}; value never passes the end stops
    function automatic logic [9:0] shift_step(input logic [7:0] val, input logic inc);
        logic [9:0] r;
        r = {LIM_NONE, val};
        if (inc) begin
            if (val == SHIFT_MAX) r = {LIM_MAX, val};
            else r = {LIM_NONE, val + 8'h01};
        end else begin
            if (val == SHIFT_MIN) r = {LIM_MIN, val};
            else r = {LIM_NONE, val - 8'h01};
        end
        return r;
    endfunction

    assign sync_sel = q.sy2[q.sel];
    assign wr_fire = q.aw_v && q.w_v && !q.bvalid;

    always_comb begin
        logic [9:0] st;
        st = '0;
        d = q;
        d.save = 1'b0;
        remote_sel = 1'b0;
        force_any = 1'b0;
        force_idx = SEL_FIRST;
        lock_toggle = 1'b0;
        // two flops, then a stable-for-N-cycles filter per pin
        d.s1 = pins;
        d.s2 = q.s1;
        d.sy1 = sync_det;
        d.sy2 = q.sy1;
        for (int i = 0; i < NPIN; i++) begin
            if (q.s2[i] == q.db[i]) begin
                d.dcnt[i] = '0;
            end else if (q.dcnt[i] == DEB_W'(DEBOUNCE_CYC - 1)) begin
                d.db[i] = q.s2[i];
                d.dcnt[i] = '0;
            end else begin
                d.dcnt[i] = q.dcnt[i] + DEB_W'(1);
            end
        end
        rel_up = q.db.up && !d.db.up;
        rel_dn = q.db.down && !d.db.down;
        ev_h = (d.db.h_inc && !q.db.h_inc) || (d.db.h_dec && !q.db.h_dec);
        ev_v = (d.db.v_inc && !q.db.v_inc) || (d.db.v_dec && !q.db.v_dec);

        // backlight timing from power-up
        if (q.boot_cnt != 32'(BOOT_CYC)) begin
            d.boot_cnt = q.boot_cnt + 32'h1;
        end
        if (q.db.no_backlight) begin
            d.bl = q.boot_cnt < 32'(BOOT_SHORT_CYC);
        end else begin
            d.bl = (q.boot_cnt < 32'(BOOT_CYC)) || sync_sel;
        end

        // timed messages fall back to the scan readout
        if (q.mode >= DM_HSHIFT) begin
            if (q.msg_cnt == 32'(IDLE_CYC - 1)) begin
                d.mode = sync_sel ? DM_RATES : DM_NOSIG;
                d.lim = LIM_NONE;
                d.save = (q.mode == DM_HSHIFT) || (q.mode == DM_VSHIFT);
            end else begin
                d.msg_cnt = q.msg_cnt + 32'h1;
            end
        end else begin
            d.mode = sync_sel ? DM_RATES : DM_NOSIG;
        end

        // hold timer for lockout
        if (q.db.up || q.db.down) begin
            if (q.hold_cnt != 32'(HOLD_CYC - 1)) begin
                d.hold_cnt = q.hold_cnt + 32'h1;
            end else if (!q.held_long) begin
                lock_toggle = 1'b1;
                d.lock = !q.lock;
                d.held_long = 1'b1;
                d.mode = q.lock ? DM_LOCK_OFF : DM_LOCK_ON;
                d.msg_cnt = '0;
            end
        end else begin
            d.hold_cnt = '0;
            d.held_long = 1'b0;
        end

        // steps act on release so a long press is not also a step
        if ((rel_up || rel_dn) && !q.held_long) begin
            if (q.lock) begin
                d.mode = DM_LOCK_ON;
                d.msg_cnt = '0;
            end else if (rel_dn) begin
                d.sel = (q.sel == SEL_LAST) ? SEL_FIRST : q.sel + 2'h1;
            end else begin
                d.sel = (q.sel == SEL_FIRST) ? SEL_LAST : q.sel - 2'h1;
            end
        end

        if (ev_h || ev_v) begin
            d.msg_cnt = '0;
            if (q.lock) begin
                d.mode = DM_LOCK_ON;
            end else if (q.db.centering_bypass) begin
                d.mode = DM_BYPASS;
            end else if (ev_h) begin
                st = shift_step(q.hs[q.sel], d.db.h_inc && !q.db.h_inc);
                d.hs[q.sel] = st[7:0];
                d.lim = limit_type'(st[9:8]);
                d.mode = DM_HSHIFT;
            end else begin
                st = shift_step(q.vs[q.sel], d.db.v_inc && !q.db.v_inc);
                d.vs[q.sel] = st[7:0];
                d.lim = limit_type'(st[9:8]);
                d.mode = DM_VSHIFT;
            end
        end

        // register bus: write address and data taken in either order
        if (s_axi_awvalid && !q.aw_v) begin
            d.aw_v = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_v) begin
            d.w_v = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (wr_fire) begin
            d.aw_v = 1'b0;
            d.w_v = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            case (q.aw_addr)
                ADDR_CTRL: begin
                    if (q.wstrb[0] && q.wdata[1:0] <= SEL_LAST) begin
                        remote_sel = 1'b1;
                        d.sel = q.wdata[1:0];
                    end
                end
                ADDR_STATUS: begin
                    d.bresp = RESP_OKAY;
                end
                ADDR_SHIFT: begin
                    if (q.wstrb[0]) d.hs[q.sel] = q.wdata[7:0];
                    if (q.wstrb[1]) d.vs[q.sel] = q.wdata[15:8];
                    if (q.wstrb[0] || q.wstrb[1]) d.save = 1'b1;
                end
                ADDR_RATE: begin
                    if (q.wstrb[0]) d.v_rate[7:0] = q.wdata[7:0];
                    if (q.wstrb[1]) d.v_rate[15:8] = q.wdata[15:8];
                    if (q.wstrb[2]) d.h_rate[7:0] = q.wdata[23:16];
                    if (q.wstrb[3]) d.h_rate[15:8] = q.wdata[31:24];
                end
                default: begin
                    d.bresp = RESP_SLVERR;
                end
            endcase
        end else if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid) begin
            if (s_axi_rready) d.rvalid = 1'b0;
        end else if (s_axi_arvalid) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            case (s_axi_araddr)
                ADDR_CTRL: d.rdata = {29'h0, q.lock, q.sel};
                ADDR_STATUS: d.rdata = {25'h0, q.bl, sync_sel, q.mode, q.lim};
                ADDR_SHIFT: d.rdata = {16'h0, q.vs[q.sel], q.hs[q.sel]};
                ADDR_RATE: d.rdata = {q.h_rate, q.v_rate};
                default: begin
                    d.rdata = 32'h0;
                    d.rresp = RESP_SLVERR;
                end
            endcase
        end

        // closures last so a held short keeps forcing its input
        if (!q.db.auto_switch) begin
            for (int i = 2; i >= 0; i--) begin
                if (!q.db.cc_n[i]) begin
                    force_any = 1'b1;
                    force_idx = 2'(i);
                end
            end
            if (force_any) d.sel = force_idx;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.s1 <= PINS_RESET;
            q.s2 <= PINS_RESET;
            q.db <= PINS_RESET;
            q.sel <= SEL_FIRST;
            q.bl <= 1'b1;
            q.mode <= DM_NOSIG;
            q.lim <= LIM_NONE;
            q.hs <= {3{SHIFT_RESET}};
            q.vs <= {3{SHIFT_RESET}};
        end else begin
            q <= d;
        end
    end

    assign sel = q.sel;
    assign input_led = 3'h1 << q.sel;
    assign audio_mute = (q.sel == SEL_NO_AUDIO);
    assign backlight = q.bl;
    assign disp = '{mode: q.mode, lim: q.lim, h_rate: q.h_rate, v_rate: q.v_rate};
    assign shift_save = q.save;
    assign save_input = q.sel;
    assign h_shift = q.hs[q.sel];
    assign v_shift = q.vs[q.sel];
    assign id_sel.src = (q.db.rotary == ROT_PASS) ? ID_PASS :
        (q.db.rotary != ROT_USER) ? ID_PRESET :
        (user_id_valid ? ID_USER : ID_EMPTY);
    assign id_sel.preset = q.db.rotary;
    assign id_sel.rate_50hz = q.db.freq_50hz;
    assign s_axi_awready = !q.aw_v;
    assign s_axi_wready = !q.w_v;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence seq_free_step;
        !q.held_long && !q.lock && !remote_sel && !force_any;
    endsequence
    sequence seq_hold_done;
        (q.db.up || q.db.down) && q.hold_cnt == 32'(HOLD_CYC - 1) && !q.held_long;
    endsequence
    sequence seq_shift_expire;
        (q.mode == DM_HSHIFT || q.mode == DM_VSHIFT) && q.msg_cnt == 32'(IDLE_CYC - 1)
            && !ev_h && !ev_v && !lock_toggle && !((rel_up || rel_dn) && !q.held_long);
    endsequence

    AST_ADVANCE: assert property ((rel_dn and seq_free_step) |=>
        sel == (($past(sel) == SEL_LAST) ? SEL_FIRST : $past(sel) + 2'h1))
        else $error("down step did not advance input");
    AST_BACK: assert property (((rel_up && !rel_dn) and seq_free_step) |=>
        sel == (($past(sel) == SEL_FIRST) ? SEL_LAST : $past(sel) - 2'h1))
        else $error("up step did not go back");
    AST_LOCK_SHIFT: assert property ((ev_h || ev_v) && q.lock && !wr_fire |=>
        $stable(q.hs) && $stable(q.vs) && disp.mode == DM_LOCK_ON)
        else $error("shift moved during lockout");
    AST_HOLD: assert property (seq_hold_done |=> q.lock != $past(q.lock)
        && disp.mode inside {DM_LOCK_ON, DM_LOCK_OFF} && q.held_long)
        else $error("hold did not toggle lockout");
    AST_LOCK_STEP: assert property ((rel_up || rel_dn) && !q.held_long && q.lock && !remote_sel
        && !force_any && !lock_toggle |=> $stable(sel) && disp.mode == DM_LOCK_ON)
        else $error("step accepted during lockout");
    AST_REMOTE: assert property (remote_sel && !force_any |=> sel == $past(q.wdata[1:0]))
        else $error("remote select not applied");
    AST_BL_SYNC: assert property (!q.db.no_backlight && sync_sel |=> backlight)
        else $error("backlight off with signal present");
    AST_BL_OFF: assert property (q.db.no_backlight && q.boot_cnt >= 32'(BOOT_SHORT_CYC) |=> !backlight)
        else $error("backlight lit with disable switch on");
    AST_NOSIG: assert property (disp.mode == DM_NOSIG |-> !$past(sync_sel))
        else $error("no-signal shown while sync present");
    AST_RATES: assert property (disp.mode == DM_RATES |-> $past(sync_sel))
        else $error("rates shown without sync");
    AST_IDLE_SAVE: assert property (seq_shift_expire |=> shift_save
        && disp.mode inside {DM_RATES, DM_NOSIG} && disp.lim == LIM_NONE)
        else $error("shift idle did not save and return");
    AST_BYPASS: assert property ((ev_h || ev_v) && !q.lock && q.db.centering_bypass && !wr_fire |=>
        $stable(q.hs) && $stable(q.vs) && disp.mode == DM_BYPASS)
        else $error("shift moved with bypass on");
    AST_MUTE: assert property (audio_mute == (sel == SEL_NO_AUDIO))
        else $error("audio mute wrong");
    AST_LED: assert property (input_led == (3'h1 << sel) && $onehot(input_led))
        else $error("indicator does not match input");
    AST_FORCE: assert property (force_any |=> sel == $past(force_idx) && !$past(q.db.auto_switch))
        else $error("closure did not force input");
    AST_PASS: assert property (q.db.rotary == ROT_PASS |-> id_sel.src == ID_PASS)
        else $error("position F not pass-through");
endmodule

// ==== bench/panel_model.sv ====
`timescale 1ns/1ns
module panel_model (
    input wire logic aclk,
    output panel_pkg::pins_type pins,
    output logic [2:0] sync_det,
    output logic user_id_valid
);
    import panel_pkg::*;
    pins_type pins_q = PINS_RESET;
    logic [2:0] sync_q = 3'h0;
    logic user_q = 1'b0;
    assign pins = pins_q;
    assign sync_det = sync_q;
    assign user_id_valid = user_q;
    // toggle springs back to centre once let go
    task automatic press(input logic dn, input int cyc);
        @(posedge aclk);
        pins_q.down <= dn;
        pins_q.up <= !dn;
        repeat (cyc) @(posedge aclk);
        pins_q.down <= 1'b0;
        pins_q.up <= 1'b0;
        repeat (14) @(posedge aclk);
    endtask
    // one detent: 0 h_inc, 1 h_dec, 2 v_inc, 3 v_dec
    task automatic turn(input int k);
        @(posedge aclk);
        pins_q[14-k] <= 1'b1;
        repeat (8) @(posedge aclk);
        pins_q[14-k] <= 1'b0;
        repeat (14) @(posedge aclk);
    endtask
endmodule

// ==== bench/test_front_panel_input_selector.sv ====
`timescale 1ns/1ns
module test_front_panel_input_selector;
    import panel_pkg::*;
    typedef struct {logic [31:0] val; logic [31:0] mask; logic [10:0] ext; logic [10:0] emask;} note_type;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, audio_mute, backlight, shift_save;
    logic [7:0] awaddr, araddr, h_shift, v_shift;
    logic [31:0] wdata, rdata, x, y;
    logic [3:0] wstrb, pos, strb;
    logic [1:0] bresp, rresp, sel, src, save_input;
    logic [2:0] input_led, sync_det;
    logic [15:0] hv;
    logic user_id_valid;
    pins_type pins;
    id_sel_type id_sel;
    disp_type disp;
    note_type rq[$];
    note_type n;
    logic [1:0] bq[$], rrq[$];
    int miscompares = 0, compares = 0, cycles = 0, saves = 0, s0, seed, i;

    panel_model pm (.aclk(aclk), .pins(pins), .sync_det(sync_det), .user_id_valid(user_id_valid));
    front_panel_input_selector #(.DEBOUNCE_CYC(4), .HOLD_CYC(40), .BOOT_CYC(60), .BOOT_SHORT_CYC(20),
        .IDLE_CYC(30)) uut (.aclk(aclk), .aresetn(aresetn), .pins(pins), .sync_det(sync_det),
        .user_id_valid(user_id_valid), .input_led(input_led), .sel(sel), .audio_mute(audio_mute),
        .backlight(backlight), .disp(disp), .shift_save(shift_save), .save_input(save_input), .h_shift(h_shift),
        .v_shift(v_shift),
        .id_sel(id_sel), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    task automatic end_of_test;
        if (miscompares == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bq.push_back(r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m, input logic [10:0] e,
        input logic [10:0] em);
        rq.push_back('{v, m, e, em});
        rrq.push_back((a inside {ADDR_CTRL, ADDR_STATUS, ADDR_SHIFT, ADDR_RATE}) ? RESP_OKAY : RESP_SLVERR);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask
    task automatic rc(input logic [2:0] v);
        rd(ADDR_CTRL, {29'h0, v}, 32'h7, {v[1:0] == SEL_NO_AUDIO, 3'h1 << v[1:0], 7'h0}, 11'h780);
    endtask
    task automatic rs(input logic [6:0] v, input logic [6:0] m);
        rd(ADDR_STATUS, {25'h0, v}, {25'h0, m}, 11'h0, 11'h0);
    endtask

    // watcher: oldest note against each response
    always @(posedge aclk) begin
        if (rvalid && rready && rq.size() > 0) begin
            n = rq.pop_front();
            check(rdata & n.mask, n.val & n.mask);
            check({21'h0, {audio_mute, input_led, id_sel} & n.emask}, {21'h0, n.ext & n.emask});
            check({30'h0, rresp}, {30'h0, rrq.pop_front()});
        end
        if (bvalid && bready && bq.size() > 0) check({30'h0, bresp}, {30'h0, bq.pop_front()});
    end
    always @(posedge aclk) begin
        cycles++;
        if (shift_save === 1'b1) saves++;
        if (cycles == 5000) begin
            miscompares++;
            end_of_test();
        end
    end
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    initial begin
        seed = 33;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        strb = 4'hF;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rc(3'h0);
        rs({1'b1, 1'b0, DM_NOSIG, LIM_NONE}, 7'h7F);
        rd(ADDR_CTRL, 0, 0, {4'h1, ID_PRESET, ROT_DEFAULT, 1'b0}, 11'h7F);
        for (i = 1; i <= 3; i++) begin
            pm.press(1'b1, 8);
            rc(3'(i % 3));
        end
        pm.press(1'b0, 8);
        rc(3'h2);
        pm.press(1'b0, 8);
        rc(3'h1);
        pm.press(1'b1, 50);
        rs({2'h0, DM_LOCK_ON, LIM_NONE}, 7'h1F);
        rc(3'h5);
        pm.press(1'b1, 8);
        rc(3'h5);
        rs({2'h0, DM_LOCK_ON, LIM_NONE}, 7'h1F);
        pm.turn(0);
        rd(ADDR_SHIFT, 32'h8080, 32'hFFFF, 11'h0, 11'h0);
        wr(ADDR_CTRL, 32'h2, RESP_OKAY);
        rc(3'h6);
        pm.press(1'b1, 50);
        rs({2'h0, DM_LOCK_OFF, LIM_NONE}, 7'h1F);
        rc(3'h2);
        wr(ADDR_CTRL, 32'h3, RESP_OKAY);
        rc(3'h2);
        wr(8'h10, 32'h1, RESP_SLVERR);
        rd(8'h10, 32'h0, 32'hFFFFFFFF, 11'h0, 11'h0);
        x = $random(seed);
        hv = x[15:0] & 16'h7F7F | 16'h0101;
        wr(ADDR_SHIFT, {16'h0, hv}, RESP_OKAY);
        rd(ADDR_SHIFT, {16'h0, hv}, 32'hFFFF, 11'h0, 11'h0);
        s0 = saves;
        pm.turn(0);
        rs({2'h0, DM_HSHIFT, LIM_NONE}, 7'h1F);
        rd(ADDR_SHIFT, {16'h0, hv[15:8], hv[7:0] + 8'h01}, 32'hFFFF, 11'h0, 11'h0);
        check({14'h0, save_input, v_shift, h_shift}, {14'h0, 2'h2, hv[15:8], hv[7:0] + 8'h01});
        repeat (40) @(posedge aclk);
        check(saves - s0, 1);
        rs({2'h0, DM_NOSIG, LIM_NONE}, 7'h1F);
        wr(ADDR_SHIFT, 32'h00FF, RESP_OKAY);
        pm.turn(0);
        rs({2'h0, DM_HSHIFT, LIM_MAX}, 7'h1F);
        pm.turn(3);
        rs({2'h0, DM_VSHIFT, LIM_MIN}, 7'h1F);
        rd(ADDR_SHIFT, 32'h00FF, 32'hFFFF, 11'h0, 11'h0);
        pm.pins_q.centering_bypass <= 1'b1;
        pm.turn(2);
        rs({2'h0, DM_BYPASS, LIM_NONE}, 7'h1C);
        rd(ADDR_SHIFT, 32'h00FF, 32'hFFFF, 11'h0, 11'h0);
        pm.pins_q.centering_bypass <= 1'b0;
        pm.sync_q <= 3'h7;
        repeat (40) @(posedge aclk);
        rs({1'b1, 1'b1, DM_RATES, LIM_NONE}, 7'h7C);
        x = $random(seed);
        wr(ADDR_RATE, x, RESP_OKAY);
        rd(ADDR_RATE, x, 32'hFFFFFFFF, 11'h0, 11'h0);
        y = $random(seed);
        strb = y[3:0];
        wr(ADDR_RATE, y, RESP_OKAY);
        strb = 4'hF;
        for (i = 0; i < 4; i++) if (y[i]) x[8*i+:8] = y[8*i+:8];
        check({disp.h_rate, disp.v_rate}, x);
        rd(ADDR_RATE, x, 32'hFFFFFFFF, 11'h0, 11'h0);
        pm.sync_q <= 3'h0;
        repeat (5) @(posedge aclk);
        rs({1'b0, 1'b0, DM_NOSIG, LIM_NONE}, 7'h7C);
        pm.pins_q.cc_n <= 3'b101;
        repeat (14) @(posedge aclk);
        rc(3'h1);
        pm.press(1'b1, 8);
        rc(3'h1);
        pm.pins_q.cc_n <= 3'b111;
        pm.pins_q.auto_switch <= 1'b1;
        repeat (14) @(posedge aclk);
        pm.pins_q.cc_n <= 3'b011;
        repeat (14) @(posedge aclk);
        rc(3'h1);
        pm.pins_q.cc_n <= 3'b111;
        for (i = 0; i < 5; i++) begin
            x = $random(seed);
            pos = (i < 2) ? ROT_USER : (i == 2) ? 4'h1 : (i == 3) ? 4'hE : ROT_PASS;
            pm.pins_q.rotary <= pos;
            pm.pins_q.freq_50hz <= x[0];
            pm.user_q <= i[0];
            repeat (14) @(posedge aclk);
            src = (pos == ROT_PASS) ? ID_PASS : (pos == ROT_USER) ? (i[0] ? ID_USER : ID_EMPTY) : ID_PRESET;
            rd(ADDR_CTRL, 0, 0, {4'h0, src, pos, x[0]}, (src == ID_PRESET) ? 11'h7F : 11'h7E);
        end
        pm.pins_q.no_backlight <= 1'b1;
        pm.sync_q <= 3'h1;
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rs({1'b1, 1'b1, 5'h0}, 7'h60);
        repeat (30) @(posedge aclk);
        rs({1'b0, 1'b1, 5'h0}, 7'h60);
        end_of_test();
    end
endmodule
